// ---- verilog/adc_port_pkg.sv ----
// Purpose: Shared constants and types for the converter serial result port.
// Assumes: 32-bit AHB-Lite register access, one aligned word per register.
// Notes: Shared pin index 0..4 stands for parallel result bits 5..9.
`default_nettype none
package adc_port_pkg;
	localparam int RESULT_WIDTH = 16;
	localparam int CHAIN_DELAY = 16;
	localparam int SHARED_WIDTH = 5;
	localparam int SYNC_WIDTH = 9;
	localparam logic [4:0] LAST_BIT = 5'h0f;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] MASK_OFFSET = 8'h08;
	localparam logic [7:0] STATE_OFFSET = 8'h0c;
	localparam logic [7:0] RESULT_OFFSET = 8'h10;

	// Control fields
	localparam int CTRL_READ_ENABLE_BIT = 0;
	localparam int CTRL_DIV_LSB = 4;
	localparam int CTRL_DIV_WIDTH = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [3:0] DIV_RESET = 4'h0;

	// Event bits, shared by status and mask
	localparam int EVT_CONV_DONE = 0;
	localparam int EVT_READ_DONE = 1;
	localparam int EVT_INCOMPLETE = 2;
	localparam int EVT_WIDTH = 3;
	localparam logic [2:0] EVT_RESET = 3'h0;

	// State register fields
	localparam int STATE_LSB = 0;
	localparam int COUNT_LSB = 4;
	localparam int PINS_LSB = 12;

	// Shared pin drive patterns, enable low while driven
	localparam logic [4:0] OE_N_PARALLEL = 5'h00;
	localparam logic [4:0] OE_N_SERIAL = 5'h17;
	localparam int SDO_INDEX = 3;
	localparam int CHAIN_INDEX = 2;
	localparam int INVCLK_INDEX = 1;
	localparam int FSPOL_INDEX = 0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_READ = 2'h1,
		ST_CHAIN = 2'h3
	} port_state_type;

	// Coding select high keeps straight binary, low flips the top bit
	function automatic logic [15:0] code_result(input logic [15:0] raw, input logic straight);
		code_result = {raw[15] ^ ~straight, raw[14:0]};
	endfunction
endpackage
`default_nettype wire

// ---- verilog/shift_if.sv ----
// Purpose: Control and data path between the port sequencer and the shift register.
// Assumes: Single clock domain, hclk.
// Notes: Load wins over shift when both are high.
`timescale 1ns/100ps
`default_nettype none
interface shift_if;
	logic load;
	logic shift;
	logic [15:0] load_value;
	logic chain_bit;
	logic [15:0] word;
	modport ctrl (output load, output shift, output load_value, output chain_bit, input word);
	modport shifter (input load, input shift, input load_value, input chain_bit, output word);
endinterface
`default_nettype wire

// ---- verilog/pin_sync.sv ----
// Purpose: Two-stage synchroniser for pin-level inputs.
// Assumes: Inputs are levels; pulses shorter than one hclk period may be missed.
// Notes: First stage feeds the second stage only.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // pin_sync
`default_nettype wire

// ---- verilog/result_shifter.sv ----
// Purpose: Result shift register, top bit presented on the serial output.
// Assumes: Load and shift come from the sequencer on hclk.
// Notes: Chain data enters at the bottom, so it appears after a full word.
`timescale 1ns/100ps
`default_nettype none
module result_shifter (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Sequencer side
	shift_if.shifter sh
);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sh.word <= 16'h0000;
		else if (sh.load)
			sh.word <= sh.load_value;
		else if (sh.shift)
			sh.word <= {sh.word[14:0], sh.chain_bit}; // [RULE9]
	end

	AST_MSB_FIRST: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
		sh.load |=> sh.word[15] == $past(sh.load_value[15]) ##1 (sh.word[15] ==
		$past(sh.word[14]) || $past(sh.load) || !$past(sh.shift)))
		else $error("top bit of loaded result not presented first");
endmodule // result_shifter
`default_nettype wire

// ---- verilog/adc_serial_port.sv ----
// Purpose: Serial or parallel result port of a sampling converter, AHB-Lite control.
// Assumes: Converter core signals are on hclk; pins and the serial clock are not.
// Notes: Read enable in the control register stands in for chip select and read.
// How it works
// [RULE1] Port select low: shared pins drive result bits five to nine.
// [RULE2] Frame sync polarity low gives active high sync, high gives active low.
// [RULE3] Clock invert flips serial clock, driven or received.
// [RULE4] Clock source select chooses chain input or read mode for the shared pin.
// [RULE5] External clock: chain input carries another converter's result onto our output.
// [RULE6] Chain input level reaches the serial output after sixteen clock periods.
// [RULE7] Internal clock, read mode high: shift out during conversion.
// [RULE8] Internal clock, read mode low: shift out after conversion finishes.
// [RULE9] Result leaves the shift register top bit first.
// [RULE10] Serial result coding follows the coding select input.
// [RULE11] Internal clock: each output bit stable across both clock edges.
// [RULE12] External clock, no invert: change data on rising edge.
// [RULE13] External clock, invert: change data on falling edge.
// [RULE14] Frame sync stays active while serial data is valid; code drives it active only in internal clock reads.
// [RULE15] Source low drives internal clock out; high uses external clock.
// [RULE16] Coding high is straight binary, low inverts the top bit.
// [RULE17] External read unfinished at next conversion: discard, pulse incomplete flag.
// [RULE18] Parallel mode ignores serial configuration pins and drives them as outputs.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_port
	import adc_port_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter core
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic [adc_port_pkg::RESULT_WIDTH-1:0] conv_result,
	// Mode pins
	input wire logic port_select,
	input wire logic clock_source_select,
	input wire logic output_coding_select,
	// Shared pins, result bits five to nine
	input wire logic [adc_port_pkg::SHARED_WIDTH-1:0] shared_in,
	output logic [adc_port_pkg::SHARED_WIDTH-1:0] shared_out,
	output logic [adc_port_pkg::SHARED_WIDTH-1:0] shared_oe_n,
	// Serial clock pin
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	// Serial status pins
	output logic frame_sync,
	output logic incomplete_read_flag,
	// Interrupt
	output logic irq
);
	import adc_port_pkg::*;

	logic [SYNC_WIDTH-1:0] sync_q;
	logic port_sel_s;
	logic ext_s;
	logic ob_s;
	logic sclk_s;
	logic [SHARED_WIDTH-1:0] pins_s;
	logic frame_sync_polarity;
	logic serial_clock_invert;
	logic readmode_or_chain_input;
	logic sclk_eff;
	logic sclk_eff_q;
	logic act_edge;
	logic busy_q;
	logic busy_rise;
	logic [15:0] last_result;
	logic [15:0] coded_last;
	logic [31:0] ctrl;
	logic read_enable;
	logic [EVT_WIDTH-1:0] status;
	logic [EVT_WIDTH-1:0] mask;
	logic [EVT_WIDTH-1:0] events;
	port_state_type state;
	port_state_type next_state;
	logic [4:0] bit_count;
	logic [3:0] quarter_count;
	logic [1:0] phase;
	logic bit_end;
	logic clk_level;
	logic start_int;
	logic start_ext;
	logic overrun;
	logic ahb_write;
	logic ahb_read;
	logic [7:0] ahb_addr;
	logic [31:0] read_mux;

	shift_if sh ();

	pin_sync #(
		.WIDTH(SYNC_WIDTH)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({port_select, clock_source_select, output_coding_select, sclk_in, shared_in}),
		.q(sync_q)
	);

	result_shifter u_shifter (
		.hclk(hclk),
		.hresetn(hresetn),
		.sh(sh.shifter)
	);

	assign {port_sel_s, ext_s, ob_s, sclk_s, pins_s} = sync_q;
	// Serial configuration is read only while the serial port is selected
	assign frame_sync_polarity = port_sel_s & pins_s[FSPOL_INDEX]; // [RULE18]
	assign serial_clock_invert = port_sel_s & pins_s[INVCLK_INDEX]; // [RULE18]
	assign readmode_or_chain_input = port_sel_s & pins_s[CHAIN_INDEX]; // [RULE4]
	assign read_enable = ctrl[CTRL_READ_ENABLE_BIT];
	assign coded_last = code_result(last_result, ob_s); // [RULE16]

	// Received clock, inverted when asked, active on the rise of the result
	assign sclk_eff = sclk_s ^ serial_clock_invert; // [RULE3]
	assign act_edge = sclk_eff & ~sclk_eff_q; // [RULE12] [RULE13]
	assign busy_rise = conv_busy & ~busy_q;

	// Read during conversion uses the held word; read after uses the fresh one
	assign start_int = port_sel_s & ~ext_s & read_enable & (state == ST_IDLE) &
		(readmode_or_chain_input ? busy_rise : conv_done); // [RULE7] [RULE8]
	assign start_ext = port_sel_s & ext_s & read_enable & conv_done; // [RULE15]
	assign overrun = start_ext & (state == ST_READ); // [RULE17]
	assign bit_end = (phase == 2'h3) && (quarter_count == ctrl[CTRL_DIV_LSB +: CTRL_DIV_WIDTH]);
	assign clk_level = (state == ST_READ) && !ext_s && (phase == 2'h1 || phase == 2'h2);

	assign sh.load = start_int | start_ext;
	assign sh.load_value = code_result(readmode_or_chain_input && !ext_s ? last_result :
		conv_result, ob_s); // [RULE10] [RULE16]
	assign sh.chain_bit = ext_s & readmode_or_chain_input; // [RULE5]
	assign sh.shift = (state != ST_IDLE) && (ext_s ? act_edge : bit_end); // [RULE11]

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sclk_eff_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			sclk_eff_q <= sclk_eff;
			busy_q <= conv_busy;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			last_result <= 16'h0000;
		else if (conv_done)
			last_result <= conv_result;
	end

	always_comb
	begin
		next_state = state;
		if (!port_sel_s || !read_enable)
			next_state = ST_IDLE;
		else if (sh.load)
			next_state = ST_READ;
		else if (sh.shift && state == ST_READ && bit_count == LAST_BIT)
			next_state = ext_s ? ST_CHAIN : ST_IDLE; // [RULE6]
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			bit_count <= 5'h00;
		else if (sh.load || next_state == ST_IDLE)
			bit_count <= 5'h00;
		else if (sh.shift && state == ST_READ)
			bit_count <= bit_count + 5'h01;
	end

	// Data moves at the phase wrap, clock edges fall mid-bit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			quarter_count <= 4'h0;
			phase <= 2'h0;
		end
		else if (sh.load || state != ST_READ || ext_s)
		begin
			quarter_count <= 4'h0;
			phase <= 2'h0;
		end
		else if (quarter_count == ctrl[CTRL_DIV_LSB +: CTRL_DIV_WIDTH])
		begin
			quarter_count <= 4'h0;
			phase <= phase + 2'h1; // [RULE11]
		end
		else
			quarter_count <= quarter_count + 4'h1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sclk_out <= 1'b0;
			sclk_oe_n <= 1'b1;
			frame_sync <= 1'b0;
			incomplete_read_flag <= 1'b0;
		end
		else
		begin
			sclk_out <= clk_level ^ serial_clock_invert; // [RULE3]
			sclk_oe_n <= !(port_sel_s && !ext_s); // [RULE15]
			frame_sync <= ((state == ST_READ) && !ext_s) ^ frame_sync_polarity; // [RULE2] [RULE14]
			incomplete_read_flag <= overrun; // [RULE17]
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			shared_out <= 5'h00;
			shared_oe_n <= OE_N_SERIAL;
		end
		else if (!port_sel_s)
		begin
			shared_out <= coded_last[9:5]; // [RULE1]
			shared_oe_n <= OE_N_PARALLEL; // [RULE18]
		end
		else
		begin
			shared_out <= {1'b0, sh.word[15], 3'h0}; // [RULE9]
			shared_oe_n <= OE_N_SERIAL;
		end
	end

	// AHB-Lite slave, one wait state on reads so a prior write is visible
	assign events = {overrun, sh.shift && state == ST_READ && bit_count == LAST_BIT, conv_done};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ahb_write <= 1'b0;
			ahb_read <= 1'b0;
			ahb_addr <= 8'h00;
		end
		else
		begin
			ahb_write <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			ahb_read <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
			if (hsel && hready && htrans == HTRANS_NONSEQ)
				ahb_addr <= haddr[7:0];
		end
	end

	always_comb
	begin
		read_mux = 32'h0000_0000;
		unique case (ahb_addr)
			CTRL_OFFSET: read_mux = ctrl;
			STATUS_OFFSET: read_mux[EVT_WIDTH-1:0] = status;
			MASK_OFFSET: read_mux[EVT_WIDTH-1:0] = mask;
			STATE_OFFSET: read_mux = {12'h000, ob_s, ext_s, port_sel_s, pins_s, 3'h0,
				bit_count, 2'h0, state};
			RESULT_OFFSET: read_mux[15:0] = coded_last;
			default: read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
		else
		begin
			hreadyout <= !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite);
			hresp <= HRESP_OKAY;
			if (ahb_read)
				hrdata <= read_mux;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl <= CTRL_RESET;
			mask <= EVT_RESET;
		end
		else if (ahb_write && ahb_addr == CTRL_OFFSET)
			ctrl <= {24'h000000, hwdata[CTRL_DIV_LSB +: CTRL_DIV_WIDTH], 3'h0,
				hwdata[CTRL_READ_ENABLE_BIT]};
		else if (ahb_write && ahb_addr == MASK_OFFSET)
			mask <= hwdata[EVT_WIDTH-1:0];
	end

	// A new event wins over a write-one clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status <= EVT_RESET;
		else if (ahb_write && ahb_addr == STATUS_OFFSET)
			status <= (status & ~hwdata[EVT_WIDTH-1:0]) | events;
		else
			status <= status | events;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end

	AST_PAR_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
		!port_sel_s |=> shared_oe_n == OE_N_PARALLEL &&
		shared_out == $past(coded_last[9:5]))
		else $error("parallel result bits not driven on shared pins");
	AST_SER_IGNORE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE18]
		!port_sel_s |=> !sclk_oe_n == 1'b0 && state == ST_IDLE)
		else $error("serial activity while parallel port selected");
	AST_SYNC_SENSE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
		(state == ST_READ && !ext_s) |=> frame_sync == !$past(frame_sync_polarity))
		else $error("frame sync not active during internal read");
	AST_SCLK_INV: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
		(state == ST_READ && !ext_s && phase == 2'h0 && quarter_count == 4'h0 && !sh.load)
		|=> sclk_out == $past(serial_clock_invert))
		else $error("driven serial clock ignores invert select");
	AST_CHAIN_IN: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
		(sh.shift && !sh.load && ext_s) |=> sh.word[0] == $past(readmode_or_chain_input))
		else $error("chain input not shifted in behind the result");
	AST_CODING: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
		(sh.load && !ext_s && !readmode_or_chain_input) |=>
		sh.word[15] == ($past(conv_result[15]) ^ !$past(ob_s)))
		else $error("serial result coding wrong");
	AST_READ_AFTER: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
		(state == ST_IDLE && port_sel_s && !ext_s && read_enable && !readmode_or_chain_input &&
		conv_done) |=> state == ST_READ)
		else $error("read after conversion did not start");
	AST_READ_DURING: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
		(state == ST_IDLE && port_sel_s && !ext_s && read_enable && readmode_or_chain_input &&
		busy_rise) |=> state == ST_READ && sh.word == code_result($past(last_result), $past(ob_s)))
		else $error("read during conversion did not start with held result");
	AST_INT_STABLE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
		(state == ST_READ && !ext_s && $changed(sh.word[15]) && !$past(sh.load)) |->
		phase == 2'h0 && !clk_level)
		else $error("serial output moved away from the bit boundary");
	AST_EXT_EDGE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
		(sh.shift && ext_s) |-> (sclk_s ^ serial_clock_invert) && !sclk_eff_q)
		else $error("external clock shift on wrong edge");
	AST_RD_ERR: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
		overrun |=> incomplete_read_flag ##1 (!incomplete_read_flag || $past(overrun)))
		else $error("incomplete read flag not pulsed");
	AST_CLK_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
		(port_sel_s && !ext_s) [*2] |-> !sclk_oe_n)
		else $error("internal clock not driven out");
endmodule // adc_serial_port
`default_nettype wire

// ---- sim/host_model.sv ----
// Purpose: Host end of the serial link, clocking the port in external mode.
// Assumes: Link clock period 80 ns, halted between frames.
// Notes: Between frames the chain line shows the inverse of its last bit.
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// Link outputs
	output logic sclk,
	output logic chain,
	// Link inputs
	input wire logic sdo,
	input wire logic inv
);
	logic active = 1'b0;
	// Start at the rest level for no invert, so the clock is never unknown
	initial
	begin
		chain = 1'b0;
		sclk = 1'b1;
	end
	// Rest at the level left by an update edge, so every frame opens with a sample
	always @(inv or active)
	begin
		if (!active)
			sclk = ~inv;
	end
	task automatic frame(input int n, input logic [15:0] cw, output logic [31:0] got);
		active = 1'b1;
		got = '0;
		#3;
		for (int k = 0; k < n; k++)
		begin
			#40 sclk = ~sclk;
			got = {got[30:0], sdo};
			chain = (k < 16) ? cw[15-k] : ~chain;
			#40 sclk = ~sclk;
		end
		#40 chain = ~chain;
		active = 1'b0;
	endtask
endmodule // host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the converter serial result port.
// Assumes: Converter core and mode pins come from the bench, external link clock from host_model.
// Notes: Random values use a fixed seed; corner cases are written by hand.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_top;
	import adc_port_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp, conv_busy, conv_done;
	logic [31:0] haddr, hwdata, hrdata, r, got;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] conv_result, v, w;
	logic port_select, clock_source_select, output_coding_select;
	logic [4:0] shared_in, shared_out, shared_oe_n, drv;
	logic sclk_in, sclk_out, sclk_oe_n, frame_sync, incomplete_read_flag, irq;
	logic fsp, inv, rm, tog, host_sclk, host_chain, seen;
	int failures = 0;
	int tests_run = 0;

	always #4 hclk = ~hclk;
	always @(posedge hclk) tog <= ~tog;
	// Undriven pins never keep a stale level
	assign drv = {tog, ~tog, clock_source_select ? host_chain : rm, inv, fsp};
	assign shared_in = (shared_oe_n & drv) | (~shared_oe_n & shared_out);
	assign sclk_in = sclk_oe_n ? host_sclk : sclk_out;

	adc_serial_port uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .conv_busy, .conv_done, .conv_result,
		.port_select, .clock_source_select, .output_coding_select, .shared_in, .shared_out,
		.shared_oe_n, .sclk_in, .sclk_out, .sclk_oe_n, .frame_sync, .incomplete_read_flag, .irq);
	host_model host (.sclk(host_sclk), .chain(host_chain), .sdo(shared_in[3]), .inv(inv));

	function automatic logic [15:0] coded(input logic [15:0] x, input logic s);
		coded = s ? x : {~x[15], x[14:0]};
	endfunction

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			failures++;
			close_out;
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask

	task automatic conv(input logic [15:0] x);
		@(posedge hclk);
		conv_done <= 1'b1;
		conv_result <= x;
		@(posedge hclk);
		conv_done <= 1'b0;
		conv_result <= ~x;
	endtask

	// Samples the data line on both clock edges of each bit and demands the same value
	task automatic capture(output logic [15:0] q);
		int n;
		int b;
		logic prev;
		logic cur;
		logic hold;
		n = 0;
		b = 0;
		prev = 1'b0;
		hold = 1'b0;
		q = '0;
		while (b < 32 && n < 3000)
		begin
			@(posedge hclk);
			n++;
			cur = sclk_out ^ inv;
			if (cur && !prev)
			begin
				q = {q[14:0], shared_out[SDO_INDEX]};
				hold = shared_out[SDO_INDEX];
				`CHK("sync_active", ~fsp, frame_sync);
				b++;
			end
			else if (!cur && prev)
			begin
				`CHK("sdo_hold", hold, shared_out[SDO_INDEX]);
				b++;
			end
			prev = cur;
		end
		if (b < 32)
		begin
			failures++;
			close_out;
		end
	endtask

	initial
	begin
		hresetn = 1'b0;
		{hsel, hwrite, conv_busy, conv_done, fsp, inv, rm, tog} = '0;
		haddr = '0;
		hwdata = '0;
		htrans = 2'h0;
		hsize = 3'h2;
		conv_result = '0;
		{port_select, clock_source_select, output_coding_select} = 3'h1;
		void'($urandom(34754));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		bus(CTRL_OFFSET, 1'b0, 32'h0);
		`CHK("ctrl_reset", CTRL_RESET, r);
		bus(MASK_OFFSET, 1'b0, 32'h0);
		`CHK("mask_reset", EVT_RESET, r[2:0]);
		bus(8'h20, 1'b1, 32'hffff_ffff);
		bus(8'h20, 1'b0, 32'h0);
		`CHK("unmapped", 32'h0, r);
		// Parallel port, serial pins wiggled to show they are ignored
		for (int c = 0; c < 2; c++)
		begin
			output_coding_select <= c[0];
			{fsp, inv, rm} <= 3'($urandom);
			v = $urandom;
			repeat (4) @(posedge hclk);
			conv(v);
			repeat (4) @(posedge hclk);
			w = coded(v, c[0]);
			`CHK("par_bits", w[9:5], shared_out);
			`CHK("par_oe_n", OE_N_PARALLEL, shared_oe_n);
			bus(RESULT_OFFSET, 1'b0, 32'h0);
			`CHK("result", w, r[15:0]);
		end
		// Internal clock, read after and during conversion
		port_select <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			rm <= m[0];
			{fsp, inv, output_coding_select} <= 3'($urandom);
			v = $urandom;
			bus(CTRL_OFFSET, 1'b1, 32'h0);
			if (m == 1)
				conv(v);
			bus(CTRL_OFFSET, 1'b1, {24'h0, 4'($urandom_range(2)), 4'h1});
			conv_busy <= 1'b1;
			if (m == 0)
			begin
				repeat (12) @(posedge hclk);
				`CHK("no_read_busy", fsp, frame_sync);
				conv_busy <= 1'b0;
				conv(v);
			end
			capture(w);
			conv_busy <= 1'b0;
			`CHK("sdo_word", coded(v, output_coding_select), w);
			repeat (8) @(posedge hclk);
			`CHK("sclk_idle", inv, sclk_out);
			`CHK("sync_idle", fsp, frame_sync);
			`CHK("sclk_drive", 1'b0, sclk_oe_n);
		end
		// External clock: read cut short by the next conversion
		clock_source_select <= 1'b1;
		bus(STATUS_OFFSET, 1'b1, 32'h7);
		bus(MASK_OFFSET, 1'b1, 32'h4);
		`CHK("sclk_recv", 1'b1, sclk_oe_n);
		conv($urandom);
		repeat (6) @(posedge hclk);
		host.frame(4, 16'h0, got);
		v = $urandom;
		conv(v);
		seen = 1'b0;
		repeat (6)
		begin
			@(posedge hclk);
			seen = seen | incomplete_read_flag;
		end
		`CHK("flag_pulse", 1'b1, seen);
		`CHK("irq_set", 1'b1, irq);
		bus(STATUS_OFFSET, 1'b0, 32'h0);
		`CHK("status", 3'h5, r[2:0]);
		bus(STATUS_OFFSET, 1'b1, 32'h7);
		repeat (2) @(posedge hclk);
		`CHK("irq_clear", 1'b0, irq);
		host.frame(16, 16'h0, got);
		`CHK("new_word", coded(v, output_coding_select), got[15:0]);
		// Daisy chain on both update edges
		for (int i = 0; i < 2; i++)
		begin
			inv <= i[0];
			bus(CTRL_OFFSET, 1'b1, 32'h0);
			bus(CTRL_OFFSET, 1'b1, 32'h1);
			v = $urandom;
			w = $urandom;
			conv(v);
			repeat (6) @(posedge hclk);
			host.frame(32, w, got);
			`CHK("chain", {coded(v, output_coding_select), w}, got);
		end
		close_out;
	end
endmodule // tb_top
`default_nettype wire
